// >>> hw/pnc_pkg.sv
// Purpose: shared constants for the partition narrowing and
//          bandwidth ceiling configuration bank
// Assumes: one register word per offset, 16 partition tags per space
// Notes:   error codes and table depths are local choices
package pnc_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_SPACES = 4;
  localparam int NUM_TAGS = 16;
  localparam int TAG_W = 4;
  localparam int NUM_RIS = 2;
  localparam int RIS_W = 1;
  localparam int ADDR_W = 12;
  localparam int FRAC_W = 16;
  localparam int WIDTH_W = 5;

  // ****************************************************************
  // offsets and fields
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CEIL = 12'h208;
  localparam logic [ADDR_W-1:0] OFS_NARROW = 12'h600;
  localparam int MARK_BIT = 16;
  localparam int HARD_BIT = 31;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [FRAC_W-1:0] NARROW_RST = 16'h0000;
  localparam logic NARROW_MARK_RST = 1'b0;
  localparam logic [FRAC_W-1:0] CEIL_FRAC_RST = 16'hFFFF;
  localparam logic CEIL_HARD_RST = 1'b0;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_RANGE = 4'h1;
  localparam logic [3:0] ERR_UNEXP_INT = 4'h2;

  // security address space of an access, gray ordered
  typedef enum logic [1:0] {
    SP_SECURE = 2'h0,
    SP_NONSEC = 2'h1,
    SP_ROOT = 2'h3,
    SP_REALM = 2'h2
  } pnc_space_type;

  // implemented fraction bits sit at the top of the field
  function automatic logic [FRAC_W-1:0] pnc_frac_mask(
    input logic [WIDTH_W-1:0] width
  );
    logic [FRAC_W-1:0] m;
    m = 16'hFFFF;
    if (width < 5'h10) begin
      m = ~(16'hFFFF >> width);
    end
    return m;
  endfunction : pnc_frac_mask

endpackage : pnc_pkg

// >>> hw/pnc_cfg_bank.sv
// Purpose: per-space narrowing map and bandwidth ceiling registers,
//          plus the ceiling decision for one lookup per cycle
// Assumes: selector and capability inputs come from same-clock logic
// Notes:   one-cycle register access, answer on the next edge
`timescale 1ns/100ps

module pnc_cfg_bank
  import pnc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic bus_req_i,
  input wire logic bus_wr_i,
  input wire pnc_space_type bus_space_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic bus_ack_o,
  output logic [31:0] bus_rdata_o,
  input wire logic [FRAC_W-1:0] selected_tag_field_i,
  input wire logic sel_internal_i,
  input wire logic [RIS_W-1:0] resource_instance_select_i,
  input wire logic cap_narrow_i,
  input wire logic cap_ris_i,
  input wire logic bandwidth_partition_cap_i,
  input wire logic cap_bw_max_i,
  input wire logic [WIDTH_W-1:0] fraction_width_field_i,
  input wire logic [FRAC_W-1:0] narrow_class_limit_i,
  output logic err_valid_o,
  output logic [3:0] err_code_o,
  input wire logic lk_req_i,
  input wire pnc_space_type lk_space_i,
  input wire logic [FRAC_W-1:0] lk_tag_i,
  input wire logic [RIS_W-1:0] lk_ris_i,
  input wire logic [FRAC_W-1:0] lk_used_i,
  input wire logic lk_under_req_i,
  output logic lk_valid_o,
  output logic lk_grant_o,
  output logic lk_block_o,
  output logic lk_low_pref_o
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [FRAC_W-1:0] nrw_map_ff [NUM_SPACES][NUM_TAGS];
  logic nrw_mark_ff [NUM_SPACES];
  logic [FRAC_W-1:0] ceil_frac_ff [NUM_SPACES][NUM_RIS][NUM_TAGS];
  logic ceil_hard_ff [NUM_SPACES][NUM_RIS][NUM_TAGS];

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic [TAG_W-1:0] tag_idx;
  logic tag_ok;
  logic [RIS_W-1:0] ris_idx;
  logic ceil_present;
  logic [FRAC_W-1:0] frac_mask;
  logic hit_nrw;
  logic hit_ceil;
  logic nrw_wr;
  logic nrw_store;
  logic nrw_bad_class;
  logic ceil_wr;
  logic [FRAC_W-1:0] nxt_class;

  // selected tag indexes the table; tags past the table are dropped
  assign tag_idx = selected_tag_field_i[TAG_W-1:0];
  assign tag_ok = (selected_tag_field_i < FRAC_W'(NUM_TAGS));
  // resource instance only counts when that selection exists
  assign ris_idx = cap_ris_i ? resource_instance_select_i : '0;
  assign ceil_present = bandwidth_partition_cap_i && cap_bw_max_i;
  assign frac_mask = pnc_frac_mask(fraction_width_field_i);

  // address decoding per page, one page per space
  always_comb begin
    hit_nrw = 1'b0;
    hit_ceil = 1'b0;
    if (!bus_req_i) begin
      hit_nrw = 1'b0;
    end else if (bus_addr_i == OFS_NARROW && cap_narrow_i) begin
      hit_nrw = 1'b1;
    end else if (bus_addr_i == OFS_CEIL && ceil_present) begin
      hit_ceil = 1'b1;
    end
  end

  // write qualification for the narrowing map
  assign nrw_wr = hit_nrw && bus_wr_i && !sel_internal_i;
  assign nxt_class = bus_wdata_i[FRAC_W-1:0];
  assign nrw_bad_class = (nxt_class > narrow_class_limit_i) ||
                         !bus_wdata_i[MARK_BIT];
  assign nrw_store = nrw_wr && !nrw_bad_class && tag_ok;
  assign ceil_wr = hit_ceil && bus_wr_i && tag_ok;

  // ****************************************************************
  // narrowing map registers
  // ****************************************************************
  // class tag per request tag, one table per space
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int s = 0; s < NUM_SPACES; s++) begin
        for (int t = 0; t < NUM_TAGS; t++) begin
          nrw_map_ff[s][t] <= NARROW_RST;
        end
      end
    end else if (nrw_store) begin
      nrw_map_ff[bus_space_i][tag_idx] <= nxt_class;
    end
  end

  // marker bit echo, kept even when the association is refused
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int s = 0; s < NUM_SPACES; s++) begin
        nrw_mark_ff[s] <= NARROW_MARK_RST;
      end
    end else if (nrw_wr) begin
      nrw_mark_ff[bus_space_i] <= bus_wdata_i[MARK_BIT];
    end
  end

  // ****************************************************************
  // bandwidth ceiling registers
  // ****************************************************************
  // index is the internal class with narrowing, else the request tag
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int s = 0; s < NUM_SPACES; s++) begin
        for (int r = 0; r < NUM_RIS; r++) begin
          for (int t = 0; t < NUM_TAGS; t++) begin
            ceil_frac_ff[s][r][t] <= CEIL_FRAC_RST;
            ceil_hard_ff[s][r][t] <= CEIL_HARD_RST;
          end
        end
      end
    end else if (ceil_wr) begin
      // unimplemented fraction bits are dropped here, so a later width
      // change cannot bring back bits that were never meant to be kept
      ceil_frac_ff[bus_space_i][ris_idx][tag_idx] <=
        bus_wdata_i[FRAC_W-1:0] & frac_mask;
      ceil_hard_ff[bus_space_i][ris_idx][tag_idx] <=
        bus_wdata_i[HARD_BIT];
    end
  end

  // ****************************************************************
  // read path and answer
  // ****************************************************************
  logic [31:0] nxt_rdata;

  // unmapped, absent or out-of-table reads return zero, except out-of-table narrowing reads, which still return the marker bit
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_nrw && !bus_wr_i && tag_ok) begin
      nxt_rdata[FRAC_W-1:0] = nrw_map_ff[bus_space_i][tag_idx];
      nxt_rdata[MARK_BIT] = nrw_mark_ff[bus_space_i];
    end else if (hit_nrw && !bus_wr_i) begin
      nxt_rdata[MARK_BIT] = nrw_mark_ff[bus_space_i];
    end else if (hit_ceil && !bus_wr_i && tag_ok) begin
      nxt_rdata[FRAC_W-1:0] =
        ceil_frac_ff[bus_space_i][ris_idx][tag_idx] & frac_mask;
      nxt_rdata[HARD_BIT] = ceil_hard_ff[bus_space_i][ris_idx][tag_idx];
    end
  end

  // every request is answered on the following edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 32'h0000_0000;
    end else begin
      bus_ack_o <= bus_req_i;
      bus_rdata_o <= nxt_rdata;
    end
  end

  // ****************************************************************
  // error status events
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_valid_o <= 1'b0;
      err_code_o <= ERR_NONE;
    end else if (hit_nrw && sel_internal_i) begin
      err_valid_o <= 1'b1;
      err_code_o <= ERR_UNEXP_INT;
    end else if (nrw_wr && nrw_bad_class) begin
      err_valid_o <= 1'b1;
      err_code_o <= ERR_RANGE;
    end else begin
      err_valid_o <= 1'b0;
      err_code_o <= ERR_NONE;
    end
  end

  // ****************************************************************
  // ceiling decision for the arbiter
  // ****************************************************************
  logic [TAG_W-1:0] lk_cls;
  logic [RIS_W-1:0] lk_ris_idx;
  logic [FRAC_W-1:0] lk_ceil;
  logic lk_hard;
  logic lk_over;

  // narrowing folds the request tag onto its class first
  always_comb begin
    lk_cls = lk_tag_i[TAG_W-1:0];
    if (cap_narrow_i) begin
      lk_cls = nrw_map_ff[lk_space_i][lk_tag_i[TAG_W-1:0]][TAG_W-1:0];
    end
  end
  assign lk_ris_idx = cap_ris_i ? lk_ris_i : '0;
  assign lk_ceil = ceil_frac_ff[lk_space_i][lk_ris_idx][lk_cls] &
                   frac_mask;
  assign lk_hard = ceil_hard_ff[lk_space_i][lk_ris_idx][lk_cls];
  assign lk_over = ceil_present && (lk_used_i > lk_ceil);

  // hard cap blocks, soft cap drops to low preference
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lk_valid_o <= 1'b0;
      lk_grant_o <= 1'b0;
      lk_block_o <= 1'b0;
      lk_low_pref_o <= 1'b0;
    end else begin
      lk_valid_o <= lk_req_i;
      lk_grant_o <= lk_req_i &&
        (!lk_over || (!lk_hard && !lk_under_req_i));
      lk_block_o <= lk_req_i && lk_over && lk_hard;
      lk_low_pref_o <= lk_req_i && lk_over && !lk_hard;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [1:0] acc_sp_ff;
  logic [TAG_W-1:0] acc_tag_ff;
  logic [RIS_W-1:0] acc_ris_ff;
  logic [FRAC_W-1:0] entry_q_ff;

  // remembers the addressed entry for the next-cycle comparison
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_sp_ff <= 2'h0;
      acc_tag_ff <= '0;
      acc_ris_ff <= '0;
      entry_q_ff <= NARROW_RST;
    end else begin
      acc_sp_ff <= bus_space_i;
      acc_tag_ff <= tag_idx;
      acc_ris_ff <= ris_idx;
      entry_q_ff <= nrw_map_ff[bus_space_i][tag_idx];
    end
  end

  sequence seq_unmarked_wr;
    nrw_wr && !bus_wdata_i[MARK_BIT];
  endsequence

  sequence seq_good_wr;
    nrw_wr && bus_wdata_i[MARK_BIT] && tag_ok &&
      (nxt_class <= narrow_class_limit_i);
  endsequence

  map_keep_a: assert property (
    seq_unmarked_wr |=> nrw_map_ff[acc_sp_ff][acc_tag_ff] == entry_q_ff)
    else $error("unmarked write changed the narrowing map");

  map_store_a: assert property (
    seq_good_wr |=> nrw_map_ff[acc_sp_ff][acc_tag_ff] ==
      $past(bus_wdata_i[FRAC_W-1:0]))
    else $error("valid class write was not stored");

  // write, one idle cycle, then a read of the same page
  marker_echo_a: assert property (
    nrw_wr ##1 !bus_req_i ##1
      (hit_nrw && !bus_wr_i && bus_space_i == $past(bus_space_i, 2))
      |=> bus_rdata_o[MARK_BIT] == $past(bus_wdata_i[MARK_BIT], 3))
    else $error("marker bit did not read back");

  range_err_a: assert property (
    seq_unmarked_wr |=> err_valid_o && err_code_o == ERR_RANGE)
    else $error("range error not reported");

  unexp_int_a: assert property (
    (hit_nrw && sel_internal_i) |=> err_valid_o &&
      err_code_o == ERR_UNEXP_INT ##1 (!err_valid_o || $past(bus_req_i)))
    else $error("internal flag misuse not reported");

  // reserved bits of the narrowing map always read zero
  nrw_resv_a: assert property (
    (hit_nrw && !bus_wr_i) |=> bus_rdata_o[31:17] == 15'h0000)
    else $error("narrowing reserved bits not zero");

  ceil_absent_a: assert property (
    (bus_req_i && bus_addr_i == OFS_CEIL && !ceil_present)
      |=> bus_ack_o && bus_rdata_o == 32'h0000_0000)
    else $error("absent ceiling register did not read zero");

  frac_mask_a: assert property (
    (hit_ceil && !bus_wr_i) |=> bus_ack_o &&
      (bus_rdata_o[15:0] & ~$past(frac_mask)) == 16'h0000 &&
      bus_rdata_o[30:16] == 15'h0000)
    else $error("unimplemented ceiling bits not zero");

  // a ceiling write keeps only the implemented fraction bits
  ceil_store_a: assert property (
    ceil_wr |=> ceil_frac_ff[acc_sp_ff][acc_ris_ff][acc_tag_ff] ==
      ($past(bus_wdata_i[FRAC_W-1:0]) & $past(frac_mask)))
    else $error("ceiling write kept unimplemented bits");

  // a partition under its ceiling is granted with no penalty
  under_grant_a: assert property (
    (lk_req_i && !lk_over) |=> lk_valid_o && lk_grant_o &&
      !lk_block_o && !lk_low_pref_o)
    else $error("under-ceiling lookup not granted");

  hard_block_a: assert property (
    (lk_req_i && lk_over && lk_hard) |=> lk_valid_o && lk_block_o &&
      !lk_grant_o && !lk_low_pref_o)
    else $error("hard cap did not block");

  soft_pref_a: assert property (
    (lk_req_i && lk_over && !lk_hard) |=> lk_low_pref_o && !lk_block_o &&
      (lk_grant_o == !$past(lk_under_req_i)))
    else $error("soft cap preference wrong");

endmodule : pnc_cfg_bank

// >>> tb/test_partition_narrowing_bw_ceiling_cfg.sv
// Purpose: self-checking bench for the narrowing and ceiling bank
// Assumes: every access is answered one cycle after its request
// Notes:   capability inputs are changed between scenarios
`timescale 1ns/100ps
module test_partition_narrowing_bw_ceiling_cfg
  import pnc_pkg::*;
;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic bus_req = 1'b0;
  logic bus_wr = 1'b0;
  pnc_space_type bus_space = SP_SECURE;
  logic [ADDR_W-1:0] bus_addr = 12'h000;
  logic [31:0] bus_wdata = 32'h0;
  logic [FRAC_W-1:0] sel_tag = 16'h0000;
  logic sel_int = 1'b0;
  logic [RIS_W-1:0] inst_sel = 1'h0;
  logic cap_nrw = 1'b1;
  logic cap_inst = 1'b1;
  logic cap_bw = 1'b1;
  logic cap_max = 1'b1;
  logic [WIDTH_W-1:0] fw = 5'h10;
  logic [FRAC_W-1:0] limit = 16'h000F;
  logic lk_req = 1'b0;
  pnc_space_type lk_space = SP_SECURE;
  logic [FRAC_W-1:0] lk_tag = 16'h0000;
  logic [RIS_W-1:0] lk_inst = 1'h0;
  logic [FRAC_W-1:0] lk_used = 16'h0000;
  logic lk_under = 1'b0;
  logic bus_ack, err_valid, lk_valid, lk_grant, lk_block, lk_low;
  logic [31:0] bus_rdata;
  logic [3:0] err_code;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  pnc_space_type sp [4] = '{SP_SECURE, SP_NONSEC, SP_ROOT, SP_REALM};

  pnc_cfg_bank pnc_cfg_bank_inst (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus_req_i(bus_req),
    .bus_wr_i(bus_wr), .bus_space_i(bus_space), .bus_addr_i(bus_addr),
    .bus_wdata_i(bus_wdata), .bus_ack_o(bus_ack), .bus_rdata_o(bus_rdata),
    .selected_tag_field_i(sel_tag), .sel_internal_i(sel_int),
    .resource_instance_select_i(inst_sel), .cap_narrow_i(cap_nrw),
    .cap_ris_i(cap_inst), .bandwidth_partition_cap_i(cap_bw),
    .cap_bw_max_i(cap_max), .fraction_width_field_i(fw),
    .narrow_class_limit_i(limit), .err_valid_o(err_valid),
    .err_code_o(err_code), .lk_req_i(lk_req), .lk_space_i(lk_space),
    .lk_tag_i(lk_tag), .lk_ris_i(lk_inst), .lk_used_i(lk_used),
    .lk_under_req_i(lk_under), .lk_valid_o(lk_valid),
    .lk_grant_o(lk_grant), .lk_block_o(lk_block), .lk_low_pref_o(lk_low)
  );

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : chk

  // selector inputs settle one edge before the access
  task automatic sel(input logic [15:0] tag, input logic internal,
                     input logic inst);
    @(posedge sys_clk_i);
    sel_tag <= tag;
    sel_int <= internal;
    inst_sel <= inst;
  endtask : sel

  // one register access, answer looked at in its single cycle
  task automatic acc(input pnc_space_type s, input logic w,
                     input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic [3:0] err);
    @(posedge sys_clk_i);
    bus_req <= 1'b1;
    bus_wr <= w;
    bus_space <= s;
    bus_addr <= a;
    bus_wdata <= wd;
    @(posedge sys_clk_i);
    bus_req <= 1'b0;
    #1;
    chk("bus_ack", {31'h0, bus_ack}, 32'h1);
    chk("bus_rdata", bus_rdata, w ? 32'h0 : exp);
    chk("err_valid", {31'h0, err_valid}, {31'h0, err != 4'h0});
    if (err != 4'h0) begin
      chk("err_code", {28'h0, err_code}, {28'h0, err});
    end
  endtask : acc

  task automatic wr(input pnc_space_type s, input logic [11:0] a,
                    input logic [31:0] wd, input logic [3:0] err);
    acc(s, 1'b1, a, wd, 32'h0, err);
  endtask : wr

  task automatic rd(input pnc_space_type s, input logic [11:0] a,
                    input logic [31:0] exp);
    acc(s, 1'b0, a, 32'h0, exp, ERR_NONE);
  endtask : rd

  // one ceiling lookup; exp is grant, block, low preference
  task automatic look(input logic [15:0] used, input logic under,
                      input logic [2:0] exp);
    @(posedge sys_clk_i);
    lk_req <= 1'b1;
    lk_tag <= 16'h0003;
    lk_used <= used;
    lk_under <= under;
    @(posedge sys_clk_i);
    lk_req <= 1'b0;
    #1;
    chk("lookup", {28'h0, lk_valid, lk_grant, lk_block, lk_low},
        {28'h0, 1'b1, exp});
  endtask : look

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc >= 2000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    sel(16'h0003, 1'b0, 1'b0);
    rd(SP_SECURE, OFS_NARROW, 32'h0000_0000);
    rd(SP_SECURE, OFS_CEIL, 32'h0000_FFFF);
    for (int i = 0; i < 4; i++) begin
      wr(sp[i], OFS_NARROW, 32'h0001_0005 + i, ERR_NONE);
    end
    for (int i = 0; i < 4; i++) begin
      rd(sp[i], OFS_NARROW, 32'h0001_0005 + i);
    end
    wr(SP_SECURE, OFS_NARROW, 32'h0000_0009, ERR_RANGE);
    rd(SP_SECURE, OFS_NARROW, 32'h0000_0005);
    wr(SP_SECURE, OFS_NARROW, 32'h0001_0010, ERR_RANGE);
    rd(SP_SECURE, OFS_NARROW, 32'h0001_0005);
    wr(SP_SECURE, OFS_NARROW, 32'hFFFF_0006, ERR_NONE);
    rd(SP_SECURE, OFS_NARROW, 32'h0001_0006);
    wr(SP_SECURE, OFS_NARROW, 32'h0001_0005, ERR_NONE);
    sel(16'h0003, 1'b0, 1'b1);
    rd(SP_SECURE, OFS_NARROW, 32'h0001_0005);
    sel(16'h0003, 1'b1, 1'b0);
    wr(SP_SECURE, OFS_NARROW, 32'h0001_0002, ERR_UNEXP_INT);
    sel(16'h0004, 1'b0, 1'b0);
    rd(SP_SECURE, OFS_NARROW, 32'h0001_0000);
    sel(16'h0003, 1'b0, 1'b0);
    rd(SP_SECURE, OFS_NARROW, 32'h0001_0005);
    // ceiling of class 5 with three implemented fraction bits
    sel(16'h0005, 1'b1, 1'b0);
    fw <= 5'h03;
    wr(SP_SECURE, OFS_CEIL, 32'hFFFF_FFFF, ERR_NONE);
    rd(SP_SECURE, OFS_CEIL, 32'h8000_E000);
    fw <= 5'h10;
    rd(SP_SECURE, OFS_CEIL, 32'h8000_E000);
    rd(SP_NONSEC, OFS_CEIL, 32'h0000_FFFF);
    sel(16'h0005, 1'b1, 1'b1);
    rd(SP_SECURE, OFS_CEIL, 32'h0000_FFFF);
    wr(SP_SECURE, OFS_CEIL, 32'h0000_8000, ERR_NONE);
    sel(16'h0005, 1'b1, 1'b0);
    rd(SP_SECURE, OFS_CEIL, 32'h8000_E000);
    cap_bw <= 1'b0;
    rd(SP_SECURE, OFS_CEIL, 32'h0000_0000);
    cap_bw <= 1'b1;
    cap_max <= 1'b0;
    wr(SP_SECURE, OFS_CEIL, 32'h0000_0000, ERR_NONE);
    rd(SP_SECURE, OFS_CEIL, 32'h0000_0000);
    cap_max <= 1'b1;
    rd(SP_SECURE, OFS_CEIL, 32'h8000_E000);
    rd(SP_SECURE, 12'h204, 32'h0000_0000);
    cap_nrw <= 1'b0;
    sel(16'h0005, 1'b0, 1'b0);
    rd(SP_SECURE, OFS_CEIL, 32'h8000_E000);
    cap_nrw <= 1'b1;
    // lookups of request tag 3, narrowed to class 5
    look(16'hF000, 1'b0, 3'b010);
    look(16'hE000, 1'b1, 3'b100);
    wr(SP_SECURE, OFS_CEIL, 32'h0000_E000, ERR_NONE);
    look(16'hF000, 1'b1, 3'b001);
    look(16'hF000, 1'b0, 3'b101);
    end_sim();
  end
endmodule : test_partition_narrowing_bw_ceiling_cfg
